// file: rtl/redriver_config_control.sv
// serial register slave and power control for the four-lane redriver
//
// Behaviour
// - presence input high puts the device in power-down; low runs normally.
// - power-down selects weak input termination and high-impedance outputs.
// - normal operation selects low-value termination on every lane not powered down by byte 2.
// - power is controlled by the presence pin or by register bits.
// - byte 2 bits 7..4 power down lanes 3..0; reset to zero.
// - two-bit flat gain code selects -3.5, -1.5, 0.5 or 2.5 dB.
// - two-bit level code selects 920, 1040, 1280 or 1370 mV.
// - four-bit boost code per lane, rising monotonically over sixteen steps.
// - address is 111, three straps, then fixed one or strap; then R/W.
// - serial enable high selects registers; low lets straps set all lanes.
// - active-low reset pin clears registers in register mode; doubles as gain strap bit 1.
// - bytes 3..6 configure lanes 0..3: boost, gain, level; reset zero.
// - bytes are accessed in order from index zero; stop after any byte.
`timescale 1ns/10ps
module redriver_config_control #(
  parameter bit LARGE_PKG = 1'b1
) (
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // serial bus pins
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // strap and mode pins
  input  wire logic        cable_present_n,
  input  wire logic        serial_cfg_enable,
  input  wire logic [3:0]  boost_addr_strap,
  input  wire logic [1:0]  level_strap,
  input  wire logic        gain_strap0,
  input  wire logic        gain1_reset_n,
  // analog controls
  output logic [3:0]       lane_power_down,
  output logic [3:0]       input_term_low,
  output logic [3:0]       output_hiz,
  output logic [15:0]      input_boost_sel,
  output logic [7:0]       flat_gain_sel,
  output logic [7:0]       output_level_sel
);
  localparam int NSYNC = 12;

  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] sync3_q;
  logic [NSYNC-1:0] filt_q;
  logic             scl_f;
  logic             sda_f;
  logic             cable_present_n_f;
  logic             ser_en_f;
  logic [3:0]       strap_f;
  logic [1:0]       level_f;
  logic             gain0_f;
  logic             gain1_f;
  logic             scl_prev_q;
  logic             sda_prev_q;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_det;
  logic             stop_det;
  logic [6:0]       own_addr;
  logic             reg_clear;

  redriver_pkg::serial_state_type state_q;
  logic [3:0]       bit_cnt_q;
  logic [7:0]       shift_q;
  logic [7:0]       tx_q;
  logic [2:0]       idx_q;
  logic             nack_q;
  logic             sda_low_q;
  logic             wr_en;
  logic [7:0]       rd_byte;

  logic [7:0]       pd_byte_q;
  logic [7:0]       lane_byte_q [4];

  assign pins = {scl_in, sda_in, cable_present_n, serial_cfg_enable,
                 boost_addr_strap, level_strap, gain_strap0, gain1_reset_n};

  // three stages; a change is taken once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_q <= '1;
      sync2_q <= '1;
      sync3_q <= '1;
      filt_q  <= '1;
    end else if (clk_en) begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= (~(sync2_q ^ sync3_q) & sync3_q)
               | ((sync2_q ^ sync3_q) & filt_q);
    end
  end

  assign {scl_f, sda_f, cable_present_n_f, ser_en_f, strap_f, level_f, gain0_f,
          gain1_f} = filt_q;

  // address: fixed high bits, strap bits, low bit by package
  assign own_addr = {redriver_pkg::ADDR_FIXED_HI, strap_f[3:1],
                     LARGE_PKG ? strap_f[0] : redriver_pkg::ADDR_FIXED_LO};

  // the shared pin resets registers only in register mode
  assign reg_clear = ser_en_f & ~gain1_f;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (clk_en) begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  assign scl_rise  = scl_f & ~scl_prev_q;
  assign scl_fall  = ~scl_f & scl_prev_q;
  assign start_det = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  assign stop_det  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

  // read data for the current index; unmapped bytes read zero
  always_comb begin
    rd_byte = redriver_pkg::RSVD_READ;
    if (idx_q == redriver_pkg::REG_LANE_PD_IDX) begin
      rd_byte = pd_byte_q;
    end else if (idx_q >= redriver_pkg::REG_LANE0_IDX &&
                 idx_q <= redriver_pkg::REG_LANE3_IDX) begin
      rd_byte = lane_byte_q[2'(idx_q - redriver_pkg::REG_LANE0_IDX)];
    end
  end

  // serial slave; never holds the clock line low
  assign wr_en = clk_en && scl_fall && state_q == redriver_pkg::ST_WR &&
                 bit_cnt_q == redriver_pkg::BITS_PER_BYTE;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q   <= redriver_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      idx_q     <= redriver_pkg::REG_RSVD0_IDX;
      nack_q    <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (clk_en) begin
      if (!ser_en_f || stop_det) begin
        state_q   <= redriver_pkg::ST_IDLE;
        sda_low_q <= 1'b0;
      end else if (start_det) begin
        state_q   <= redriver_pkg::ST_ADDR;
        bit_cnt_q <= 4'h0;
        idx_q     <= redriver_pkg::REG_RSVD0_IDX;
        sda_low_q <= 1'b0;
      end else if (scl_rise) begin
        if (state_q == redriver_pkg::ST_ADDR ||
            state_q == redriver_pkg::ST_WR) begin
          shift_q   <= {shift_q[6:0], sda_f};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end else if (state_q == redriver_pkg::ST_RD) begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end else if (state_q == redriver_pkg::ST_RD_ACK) begin
          nack_q <= sda_f;
        end
      end else if (scl_fall) begin
        unique case (state_q)
          redriver_pkg::ST_IDLE: begin
            sda_low_q <= 1'b0;
          end
          redriver_pkg::ST_ADDR: begin
            if (bit_cnt_q == redriver_pkg::BITS_PER_BYTE) begin
              if (shift_q[7:1] == own_addr) begin
                state_q   <= redriver_pkg::ST_ADDR_ACK;
                sda_low_q <= 1'b1;
                nack_q    <= shift_q[0];
              end else begin
                state_q <= redriver_pkg::ST_IDLE;
              end
            end
          end
          redriver_pkg::ST_ADDR_ACK: begin
            bit_cnt_q <= 4'h0;
            if (nack_q) begin
              state_q   <= redriver_pkg::ST_RD;
              tx_q      <= rd_byte;
              sda_low_q <= ~rd_byte[7];
            end else begin
              state_q   <= redriver_pkg::ST_WR;
              sda_low_q <= 1'b0;
            end
          end
          redriver_pkg::ST_WR: begin
            if (bit_cnt_q == redriver_pkg::BITS_PER_BYTE) begin
              state_q   <= redriver_pkg::ST_WR_ACK;
              sda_low_q <= 1'b1;
              if (idx_q != redriver_pkg::REG_LAST_IDX) begin
                idx_q <= idx_q + 3'h1;
              end
            end
          end
          redriver_pkg::ST_WR_ACK: begin
            state_q   <= redriver_pkg::ST_WR;
            bit_cnt_q <= 4'h0;
            sda_low_q <= 1'b0;
          end
          redriver_pkg::ST_RD: begin
            if (bit_cnt_q == redriver_pkg::BITS_PER_BYTE) begin
              state_q   <= redriver_pkg::ST_RD_ACK;
              sda_low_q <= 1'b0;
              if (idx_q != redriver_pkg::REG_LAST_IDX) begin
                idx_q <= idx_q + 3'h1;
              end
            end else begin
              tx_q      <= {tx_q[6:0], 1'b0};
              sda_low_q <= ~tx_q[6];
            end
          end
          redriver_pkg::ST_RD_ACK: begin
            bit_cnt_q <= 4'h0;
            if (nack_q) begin
              state_q <= redriver_pkg::ST_IDLE;
            end else begin
              state_q   <= redriver_pkg::ST_RD;
              tx_q      <= rd_byte;
              sda_low_q <= ~rd_byte[7];
            end
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = sda_low_q;
  assign scl_out = 1'b0;
  assign scl_oe  = 1'b0;

  // register file; writes to reserved bytes fall through
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (clk_en && reg_clear)) begin
      pd_byte_q <= redriver_pkg::LANE_PD_RESET;
    end else if (wr_en && idx_q == redriver_pkg::REG_LANE_PD_IDX) begin
      pd_byte_q <= shift_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < redriver_pkg::NUM_LANES; g++) begin : g_reg
      always_ff @(posedge clk_sys) begin
        if (!rst_n || (clk_en && reg_clear)) begin
          lane_byte_q[g] <= redriver_pkg::LANE_CFG_RESET;
        end else if (wr_en &&
                     idx_q == redriver_pkg::REG_LANE0_IDX + 3'(g)) begin
          lane_byte_q[g] <= shift_q;
        end
      end
    end
  endgenerate

  // settings toward the lane driver; straps rule in pin mode
  lane_cfg_if cfg ();

  assign cfg.clk_en    = clk_en;
  assign cfg.global_pd = cable_present_n_f;
  assign cfg.lane_pd   = ser_en_f ?
                         pd_byte_q[redriver_pkg::PD_LANE0_BIT +: 4] : 4'h0;

  generate
    for (g = 0; g < redriver_pkg::NUM_LANES; g++) begin : g_sel
      assign cfg.boost[g] = ser_en_f ?
        lane_byte_q[g][redriver_pkg::BOOST_LSB +: 4] : strap_f;
      assign cfg.gain[g]  = ser_en_f ?
        lane_byte_q[g][redriver_pkg::GAIN_LSB +: 2] :
        {gain1_f, gain0_f};
      assign cfg.level[g] = ser_en_f ?
        lane_byte_q[g][redriver_pkg::LEVEL_LSB +: 2] : level_f;
    end
  endgenerate

  lane_ctrl_out u_lane_out (
    .clk_sys          (clk_sys),
    .rst_n            (rst_n),
    .cfg              (cfg),
    .lane_power_down  (lane_power_down),
    .input_term_low   (input_term_low),
    .output_hiz       (output_hiz),
    .input_boost_sel  (input_boost_sel),
    .flat_gain_sel    (flat_gain_sel),
    .output_level_sel (output_level_sel)
  );
endmodule

// file: common/redriver_pkg.sv
// constants and types shared by the redriver configuration block
package redriver_pkg;
  localparam int NUM_LANES = 4;

  // register byte indexes
  localparam logic [2:0] REG_RSVD0_IDX    = 3'h0;
  localparam logic [2:0] REG_RSVD1_IDX    = 3'h1;
  localparam logic [2:0] REG_LANE_PD_IDX  = 3'h2;
  localparam logic [2:0] REG_LANE0_IDX    = 3'h3;
  localparam logic [2:0] REG_LANE3_IDX    = 3'h6;
  localparam logic [2:0] REG_LAST_IDX     = 3'h7;

  // field positions
  localparam int PD_LANE0_BIT  = 4;
  localparam int BOOST_LSB     = 4;
  localparam int GAIN_LSB      = 2;
  localparam int LEVEL_LSB     = 0;

  // reset values
  localparam logic [7:0] LANE_PD_RESET  = 8'h00;
  localparam logic [7:0] LANE_CFG_RESET = 8'h00;
  localparam logic [7:0] RSVD_READ      = 8'h00;

  // slave address layout
  localparam logic [2:0] ADDR_FIXED_HI  = 3'h7;
  localparam logic       ADDR_FIXED_LO  = 1'h1;

  // serial bits per byte
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  // flat gain codes: -3.5, -1.5, 0.5, 2.5 dB
  localparam logic [1:0] GAIN_M3P5 = 2'h0;
  localparam logic [1:0] GAIN_M1P5 = 2'h1;
  localparam logic [1:0] GAIN_P0P5 = 2'h2;
  localparam logic [1:0] GAIN_P2P5 = 2'h3;

  // output level codes: 920, 1040, 1280, 1370 mV
  localparam logic [1:0] LEVEL_920  = 2'h0;
  localparam logic [1:0] LEVEL_1040 = 2'h1;
  localparam logic [1:0] LEVEL_1280 = 2'h2;
  localparam logic [1:0] LEVEL_1370 = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK
  } serial_state_type;
endpackage

// file: common/lane_cfg_if.sv
// per-lane settings passed from the register side to the lane driver
`timescale 1ns/10ps
interface lane_cfg_if;
  logic            clk_en;
  logic            global_pd;
  logic [3:0]      lane_pd;
  logic [3:0][3:0] boost;
  logic [3:0][1:0] gain;
  logic [3:0][1:0] level;

  modport src (
    output clk_en,
    output global_pd,
    output lane_pd,
    output boost,
    output gain,
    output level
  );
  modport dst (
    input clk_en,
    input global_pd,
    input lane_pd,
    input boost,
    input gain,
    input level
  );
endinterface

// file: rtl/lane_ctrl_out.sv
// registered per-lane analog control codes
`timescale 1ns/10ps
module lane_ctrl_out (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // settings
  lane_cfg_if.dst          cfg,
  // analog controls
  output logic [3:0]       lane_power_down,
  output logic [3:0]       input_term_low,
  output logic [3:0]       output_hiz,
  output logic [15:0]      input_boost_sel,
  output logic [7:0]       flat_gain_sel,
  output logic [7:0]       output_level_sel
);
  genvar g;
  generate
    for (g = 0; g < redriver_pkg::NUM_LANES; g++) begin : g_lane
      logic pd;
      assign pd = cfg.global_pd | cfg.lane_pd[g];

      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          lane_power_down[g] <= 1'b1;
          input_term_low[g]  <= 1'b0;
          output_hiz[g]      <= 1'b1;
        end else if (cfg.clk_en) begin
          lane_power_down[g] <= pd;
          // weak pull-up in and hi-z out while down, 50 ohm otherwise
          input_term_low[g]  <= ~pd;
          output_hiz[g]      <= pd;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          input_boost_sel[4*g +: 4]  <= 4'h0;
          flat_gain_sel[2*g +: 2]    <= 2'h0;
          output_level_sel[2*g +: 2] <= 2'h0;
        end else if (cfg.clk_en) begin
          // codes pass unchanged: the analog side maps them to dB and mV
          input_boost_sel[4*g +: 4]  <= cfg.boost[g];
          flat_gain_sel[2*g +: 2]    <= cfg.gain[g];
          output_level_sel[2*g +: 2] <= cfg.level[g];
        end
      end
    end
  endgenerate
endmodule

// file: sim/redriver_sva.sv
// port assertions for the redriver configuration block
`timescale 1ns/10ps
module redriver_sva (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        scl_in,
  input wire logic        serial_cfg_enable,
  input wire logic        cable_present_n,
  input wire logic [3:0]  boost_addr_strap,
  input wire logic [1:0]  level_strap,
  input wire logic        gain_strap0,
  input wire logic        gain1_reset_n,
  input wire logic        sda_oe,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out,
  input wire logic [3:0]  lane_power_down,
  input wire logic [3:0]  input_term_low,
  input wire logic [3:0]  output_hiz,
  input wire logic [15:0] input_boost_sel,
  input wire logic [7:0]  flat_gain_sel,
  input wire logic [7:0]  output_level_sel
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire [7:0] straps = {boost_addr_strap, level_strap, gain_strap0,
                       gain1_reset_n};
  // windows of 8 cover the 5-edge pin latency with margin
  chk_term_follow: assert property (
    output_hiz == lane_power_down && input_term_low == ~lane_power_down)
    else $error("termination does not follow lane power-down");
  chk_present_down: assert property (
    (cable_present_n && clk_en) [*8] |-> lane_power_down == 4'hf)
    else $error("lanes up while cable absent");
  chk_normal_up: assert property (
    (!cable_present_n && !serial_cfg_enable && clk_en) [*8]
    |-> lane_power_down == 4'h0)
    else $error("lane down in pin mode with cable present");
  chk_pin_codes: assert property (
    (!serial_cfg_enable && clk_en && $stable(straps)) [*8]
    |-> input_boost_sel == {4{boost_addr_strap}}
    && flat_gain_sel == {4{gain1_reset_n, gain_strap0}}
    && output_level_sel == {4{level_strap}})
    else $error("pin mode codes differ from straps");
  chk_pin_quiet: assert property (
    (!serial_cfg_enable && clk_en) [*8] |-> !sda_oe)
    else $error("data line pulled in pin mode");
  chk_reg_clear: assert property (
    (serial_cfg_enable && !gain1_reset_n && !cable_present_n && clk_en)
    [*8] |-> lane_power_down == 4'h0 && input_boost_sel == 16'h0000
    && flat_gain_sel == 8'h00 && output_level_sel == 8'h00)
    else $error("registers not cleared by reset pin");
  chk_ack_scl_low: assert property (
    $rose(sda_oe) |-> !scl_in)
    else $error("data line pulled while clock high");
  chk_freeze: assert property (
    !clk_en |=> $stable(lane_power_down) && $stable(input_boost_sel))
    else $error("outputs moved while clock enable low");
  // open drain only, and the clock line is never held by the device
  chk_open_drain: assert property (
    !scl_oe && !sda_out && !scl_out)
    else $error("device drives a bus line high or holds the clock");
endmodule
bind redriver_config_control redriver_sva i_sva (.clk_sys, .rst_n,
  .clk_en, .scl_in, .serial_cfg_enable, .cable_present_n,
  .boost_addr_strap, .level_strap, .gain_strap0, .gain1_reset_n, .sda_oe,
  .scl_out, .scl_oe, .sda_out,
  .lane_power_down, .input_term_low, .output_hiz, .input_boost_sel,
  .flat_gain_sel, .output_level_sel);

// file: sim/i2c_host.sv
// serial bus host model for the register interface
`timescale 1ns/10ps
module i2c_host #(
  parameter int Q = 20
) (
  input  wire logic clk_sys,
  input  wire logic sda_oe,
  output logic      scl,
  output wire logic sda
);
  logic drv;
  // pull-up line: low while either party pulls it
  assign sda = drv & ~sda_oe;
  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic start();
    drv = 1'b0;
    hold(Q);
    scl = 1'b0;
    hold(Q);
  endtask
  task automatic stop();
    drv = 1'b0;
    hold(Q);
    scl = 1'b1;
    hold(Q);
    drv = 1'b1;
    hold(2 * Q);
  endtask
  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    drv = b;
    hold(Q);
    scl = 1'b1;
    hold(Q);
    r = sda;
    hold(Q);
    scl = 1'b0;
    hold(Q);
  endtask
  task automatic xfer(input logic [7:0] w, input logic nak,
                      output logic [7:0] r, output logic ack_n);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(nak, ack_n);
  endtask
endmodule

// file: sim/tb_top.sv
// self-checking bench for the redriver configuration block
`timescale 1ns/10ps
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_n, clk_en, cable_present_n, serial_cfg_enable;
  logic [3:0]  boost_addr_strap;
  logic [1:0]  level_strap;
  logic        gain_strap0, gain1_reset_n, scl, sda_oe;
  wire         sda;
  logic [3:0]  lane_power_down, input_term_low, output_hiz, old;
  logic [15:0] input_boost_sel;
  logic [7:0]  flat_gain_sel, output_level_sel;
  logic [7:0]  mem [8];
  logic [7:0]  q [$];
  logic [6:0]  addr;
  int          seed, n_fail, checks, cycles;
  always #20 clk_sys = ~clk_sys;
  redriver_config_control #(.LARGE_PKG(1'b1)) i_dut (.clk_sys, .rst_n,
    .clk_en, .scl_in(scl), .scl_out(), .scl_oe(), .sda_in(sda),
    .sda_out(), .sda_oe, .cable_present_n, .serial_cfg_enable,
    .boost_addr_strap, .level_strap, .gain_strap0, .gain1_reset_n,
    .lane_power_down, .input_term_low, .output_hiz, .input_boost_sel,
    .flat_gain_sel, .output_level_sel);
  i2c_host #(.Q(20)) i_host (.clk_sys, .sda_oe, .scl, .sda);
  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a hung bus transfer would otherwise never end the run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      $display("timeout");
      summarize();
    end
  end
  task automatic cmp(input string w, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", w, e, g);
    end
  endtask
  task automatic settle();
    repeat (10) @(negedge clk_sys);
  endtask
  task automatic check_out();
    logic [3:0]  pd;
    logic [15:0] b;
    logic [7:0]  g, l;
    for (int n = 0; n < 4; n++) begin
      pd[n] = cable_present_n | (serial_cfg_enable & mem[2][4+n]);
      b[4*n+:4] = serial_cfg_enable ? mem[3+n][7:4] : boost_addr_strap;
      g[2*n+:2] = serial_cfg_enable ? mem[3+n][3:2]
                                    : {gain1_reset_n, gain_strap0};
      l[2*n+:2] = serial_cfg_enable ? mem[3+n][1:0] : level_strap;
    end
    cmp("lane_power_down", pd, lane_power_down);
    cmp("output_hiz", pd, output_hiz);
    cmp("input_term_low", 4'(~pd), input_term_low);
    cmp("input_boost_sel", b, input_boost_sel);
    cmp("flat_gain_sel", g, flat_gain_sel);
    cmp("output_level_sel", l, output_level_sel);
  endtask
  task automatic wr(input logic [6:0] a);
    logic [7:0] r;
    logic       k;
    i_host.start();
    i_host.xfer({a, 1'b0}, 1'b1, r, k);
    cmp("addr_ack", a != addr, k);
    for (int i = 0; i < q.size(); i++) begin
      i_host.xfer(q[i], 1'b1, r, k);
      if (a == addr) begin
        cmp("data_ack", 0, k);
        if (i >= 2) mem[i] = q[i];
      end
    end
    i_host.stop();
  endtask
  task automatic rd();
    logic [7:0] r;
    logic       k;
    i_host.start();
    i_host.xfer({addr, 1'b1}, 1'b1, r, k);
    cmp("addr_ack", 0, k);
    for (int i = 0; i < 8; i++) begin
      i_host.xfer(8'hff, i == 7, r, k);
      cmp("read_byte", mem[i], r);
    end
    i_host.stop();
  endtask
  initial begin
    seed = 32'h268a_1eb3;
    {rst_n, clk_en, cable_present_n, serial_cfg_enable} = 4'b0110;
    {boost_addr_strap, level_strap, gain_strap0, gain1_reset_n} = '1;
    for (int i = 0; i < 8; i++) mem[i] = 8'h00;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    settle();
    check_out();
    cable_present_n = 1'b0;
    for (int t = 0; t < 6; t++) begin
      {boost_addr_strap, level_strap, gain_strap0, gain1_reset_n} =
        8'($random(seed));
      settle();
      check_out();
    end
    // bus traffic in pin mode must get no answer at the strapped address
    addr = 7'h00;
    wr({3'b111, boost_addr_strap});
    old = boost_addr_strap;
    clk_en = 1'b0;
    boost_addr_strap = ~old;
    settle();
    cmp("frozen_boost", {4{old}}, input_boost_sel);
    clk_en = 1'b1;
    $display("test pin_mode done");
    {serial_cfg_enable, gain1_reset_n} = 2'b11;
    boost_addr_strap = 4'($random(seed));
    addr = {3'b111, boost_addr_strap};
    settle();
    check_out();
    // recommended codes first: 0.5 dB gain and a level of 920 or 1280 mV
    for (int i = 0; i < 7; i++) begin
      q.push_back((8'($random(seed)) & 8'hf2) | 8'h08);
    end
    wr(addr);
    settle();
    check_out();
    rd();
    foreach (q[i]) q[i] = ~q[i];
    wr(addr ^ 7'h01);
    settle();
    check_out();
    wr(addr);
    settle();
    check_out();
    q = {8'h00, 8'h00, 8'hf0};
    wr(addr);
    settle();
    check_out();
    rd();
    $display("test register_mode done");
    cable_present_n = 1'b1;
    settle();
    check_out();
    {cable_present_n, gain1_reset_n} = 2'b00;
    for (int i = 2; i < 7; i++) mem[i] = 8'h00;
    settle();
    check_out();
    gain1_reset_n = 1'b1;
    settle();
    rd();
    $display("test register_reset done");
    summarize();
  end
endmodule
